// ===== rtl/event_status_defines.svh
// Constants for the standard event status unit: bit positions, reset values
// and identification string geometry.
// Assumes inclusion by the unit; the package does not include it; definitions only.
`ifndef EVENT_STATUS_DEFINES_SVH
`define EVENT_STATUS_DEFINES_SVH
`define SEF_OPC_BIT        0
`define SEF_QUERY_ERR_BIT  2
`define SEF_DEVICE_ERR_BIT 3
`define SEF_EXEC_ERR_BIT   4
`define SEF_CMD_ERR_BIT    5
`define SEF_USED_MASK      8'h3D
`define STB_ERRQ_BIT       2
`define STB_QUES_BIT       3
`define STB_MAV_BIT        4
`define STB_ESB_BIT        5
`define STB_RQS_BIT        6
`define STB_OPER_BIT       7
`define EEM_RESET          8'h00
`define SRE_RESET          8'h00
`define SEF_RESET          8'h00
`define ERR_CLASS_CMD      4'h1
`define ERR_CLASS_EXEC     4'h2
`define ERR_CLASS_DEV      4'h3
`define ERR_CLASS_QUERY    4'h4
`define IDN_LEN            6'h28
`endif

// ===== rtl/event_status_pkg.sv
// Types shared by the standard event status unit.
// Assumes the defines header is compiled alongside.
package event_status_pkg;
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_CLEAR_STATUS,
      CMD_WRITE_MASK,
      CMD_READ_MASK,
      CMD_READ_FLAGS,
      CMD_READ_IDENT,
      CMD_OP_COMPLETE
   } cmd_t;
   typedef enum logic [1:0] {
      OPC_IDLE,
      OPC_ARMED,
      OPC_REPORT
   } opc_state_t;
endpackage

// ===== rtl/standard_event_status_unit.sv
// Standard event status unit: event flags, enable mask, status byte,
// operation-complete tracking and the identification string.
// Assumes a command decoder on the same clock that gives one-cycle commands.
//
// What this block does
// (R1) Clear-status empties the pending error queue.
// (R2) Clear-status zeroes events, status byte; keeps masks.
// (R3) Clear-status returns completion tracking to idle.
// (R4) Event mask accepts 0..255, resets to 0.
// (R5) Masked event bits set event summary bit 5.
// (R6) Event layout: 5 cmd,4 exec,3 dev,2 query,0 opc.
// (R7) Mask query returns stored mask unchanged.
// (R8) Flags query returns contents, then clears all but events set in the read cycle.
// (R9) Class 1xx error sets command error bit.
// (R10) Class 2xx error sets execution error bit.
// (R11) Class 3xx or questionable V/I error sets device.
// (R12) Class 4xx error sets query error bit.
// (R13) Identification returns comma-separated maker/model/ratings/revisions.
// (R14) Completion bit set once commands and output settle.
// (R15) Completion request never stalls the command stream.
// (R16) Controller polls flags after completion command.
// (R17) Enabled status bits ORed into bit 6.
// (R18) Status byte layout: 7,5,4,3,2; bits 1,0 zero.
// (R19) Event bits sticky until read or cleared.
`include "event_status_defines.svh"

module standard_event_status_unit
   import event_status_pkg::*;
#(
   parameter logic [7:0] MAKER_CHAR = 8'h41 // Arbitrary neutral filler.
) (
   input  wire logic       mclk_i,
   input  wire logic       arst_n_i,
   input  wire cmd_t       cmd_i,
   input  wire logic [7:0] cmd_data_i,
   input  wire logic       err_valid_i,
   input  wire logic [3:0] err_class_i,
   input  wire logic       vi_error_i,
   input  wire logic       vi_ques_i,
   input  wire logic       busy_i,
   input  wire logic       oper_summary_i,
   input  wire logic       ques_summary_i,
   input  wire logic       msg_avail_i,
   input  wire logic [7:0] srv_enable_i,
   input  wire logic [5:0] idn_index_i,
   output logic            err_queue_flush_o,
   output logic            resp_valid_o,
   output logic [7:0]      resp_data_o,
   output logic [7:0]      status_summary_byte_o,
   output logic [7:0]      event_enable_mask_o,
   output logic [7:0]      standard_event_flags_o
);

   // Identification text, index 0 leftmost. It fills every slot: a shorter
   // literal would be padded at the front and shift every character.
   localparam logic [8*40-1:0] IDN_TEXT =
      "AAAAA,MODEL00000000,100,2,000000,1.0-1.0";

   logic [7:0] eem_q, eem_d;
   logic [7:0] sef_q, sef_d;
   logic [7:0] stb_q, stb_d;
   logic       flush_q, flush_d;
   logic       rv_q, rv_d;
   logic [7:0] rd_q, rd_d;
   opc_state_t opc_q, opc_d;
   logic [7:0] ev_set;

   function automatic logic [7:0] idn_char(input logic [5:0] idx);
      logic [5:0] pos;
      pos = 6'(`IDN_LEN - 6'h01 - idx);
      if (idx >= `IDN_LEN) begin
         idn_char = 8'h00;
      end else if (idx < 6'h05) begin
         idn_char = MAKER_CHAR;
      end else begin
         idn_char = IDN_TEXT[pos*8 +: 8];
      end
   endfunction

   always_comb begin
      ev_set = 8'h00;
      if (err_valid_i) begin
         unique case (err_class_i)
            `ERR_CLASS_CMD:   ev_set[`SEF_CMD_ERR_BIT] = 1'b1;    // see (R9)
            `ERR_CLASS_EXEC:  ev_set[`SEF_EXEC_ERR_BIT] = 1'b1;   // see (R10)
            `ERR_CLASS_DEV:   ev_set[`SEF_DEVICE_ERR_BIT] = 1'b1; // see (R11)
            `ERR_CLASS_QUERY: ev_set[`SEF_QUERY_ERR_BIT] = 1'b1;  // see (R12)
            default:          ev_set = 8'h00;
         endcase
      end
      if (vi_error_i && vi_ques_i) begin
         ev_set[`SEF_DEVICE_ERR_BIT] = 1'b1; // see (R11)
      end
      // Completion bit waits for the decoder and output to go quiet.
      if (opc_q == OPC_ARMED && !busy_i) begin
         ev_set[`SEF_OPC_BIT] = 1'b1; // see (R14)
      end
      ev_set = ev_set & `SEF_USED_MASK; // see (R6)
   end

   always_comb begin
      eem_d   = eem_q;
      opc_d   = opc_q;
      flush_d = 1'b0;
      rv_d    = 1'b0;
      rd_d    = rd_q;
      // Sticky: bits only accumulate until a read or clear.
      sef_d   = sef_q | ev_set; // see (R19)
      unique case (cmd_i)
         CMD_CLEAR_STATUS: begin
            flush_d = 1'b1;   // see (R1)
            sef_d   = 8'h00;  // see (R2)
            opc_d   = OPC_IDLE; // see (R3)
         end
         CMD_WRITE_MASK: begin
            eem_d = cmd_data_i; // see (R4)
         end
         CMD_READ_MASK: begin
            rv_d = 1'b1;
            rd_d = eem_q; // see (R7)
         end
         CMD_READ_FLAGS: begin
            rv_d  = 1'b1;
            rd_d  = sef_q; // see (R8)
            // Events landing in the read cycle survive for the next read.
            sef_d = ev_set; // see (R8)
         end
         CMD_READ_IDENT: begin
            rv_d = 1'b1;
            rd_d = idn_char(idn_index_i); // see (R13)
         end
         CMD_OP_COMPLETE: begin
            // Arming only records intent; the stream keeps flowing.
            opc_d = OPC_ARMED; // see (R15)
         end
         CMD_NONE: begin
         end
         default: begin
         end
      endcase
      if (cmd_i != CMD_CLEAR_STATUS && cmd_i != CMD_OP_COMPLETE) begin
         if (opc_q == OPC_ARMED && !busy_i) begin
            opc_d = OPC_REPORT; // see (R14)
         end else if (opc_q == OPC_REPORT) begin
            opc_d = OPC_IDLE;
         end
      end
   end

   always_comb begin
      stb_d = 8'h00;
      stb_d[`STB_OPER_BIT] = oper_summary_i;       // see (R18)
      stb_d[`STB_ESB_BIT]  = |(sef_d & eem_d);     // see (R5)
      stb_d[`STB_MAV_BIT]  = msg_avail_i;          // see (R18)
      stb_d[`STB_QUES_BIT] = ques_summary_i;       // see (R18)
      stb_d[`STB_ERRQ_BIT] = err_valid_i && cmd_i != CMD_CLEAR_STATUS;
      if (cmd_i == CMD_CLEAR_STATUS) begin
         stb_d = 8'h00; // see (R2)
      end
      stb_d[`STB_RQS_BIT] = |(stb_d & srv_enable_i & 8'hBF); // see (R17)
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         eem_q   <= `EEM_RESET;
         sef_q   <= `SEF_RESET;
         stb_q   <= 8'h00;
         flush_q <= 1'b0;
         rv_q    <= 1'b0;
         rd_q    <= 8'h00;
         opc_q   <= OPC_IDLE;
      end else begin
         eem_q   <= eem_d;
         sef_q   <= sef_d;
         stb_q   <= stb_d;
         flush_q <= flush_d;
         rv_q    <= rv_d;
         rd_q    <= rd_d;
         opc_q   <= opc_d;
      end
   end

   assign err_queue_flush_o      = flush_q;
   assign resp_valid_o           = rv_q;
   assign resp_data_o            = rd_q;
   assign status_summary_byte_o  = stb_q;
   assign event_enable_mask_o    = eem_q;
   assign standard_event_flags_o = sef_q;

   property p_clear_zeroes;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_CLEAR_STATUS |=> sef_q == 8'h00 && stb_q == 8'h00;
   endproperty
   a_clear_zeroes: assert property (p_clear_zeroes) // see (R2)
      else $error("Clear left event or status bits set.");

   property p_clear_keeps_mask;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_CLEAR_STATUS |=> eem_q == $past(eem_q);
   endproperty
   a_clear_keeps_mask: assert property (p_clear_keeps_mask) // see (R2)
      else $error("Clear changed the enable mask.");

   property p_clear_flush;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_CLEAR_STATUS
      |=> flush_q ##1 (flush_q == ($past(cmd_i) == CMD_CLEAR_STATUS));
   endproperty
   a_clear_flush: assert property (p_clear_flush) // see (R1)
      else $error("Error queue flush pulse wrong.");

   property p_clear_opc_idle;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_CLEAR_STATUS |=> opc_q == OPC_IDLE;
   endproperty
   a_clear_opc_idle: assert property (p_clear_opc_idle) // see (R3)
      else $error("Completion tracking not idle after clear.");

   property p_mask_readback;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_READ_MASK |=> rv_q && rd_q == $past(eem_q);
   endproperty
   a_mask_readback: assert property (p_mask_readback) // see (R7)
      else $error("Mask query returned wrong value.");

   property p_flags_read_clear;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_READ_FLAGS && ev_set == 8'h00
      |=> rd_q == $past(sef_q) && sef_q == 8'h00;
   endproperty
   a_flags_read_clear: assert property (p_flags_read_clear) // see (R8)
      else $error("Flags query did not return then clear.");

   property p_summary_bit;
      @(posedge mclk_i) disable iff (!arst_n_i)
      ##1 stb_q[`STB_ESB_BIT] == |(sef_q & eem_q);
   endproperty
   a_summary_bit: assert property (p_summary_bit) // see (R5)
      else $error("Event summary bit disagrees with masked flags.");

   property p_cmd_error;
      @(posedge mclk_i) disable iff (!arst_n_i)
      err_valid_i && err_class_i == `ERR_CLASS_CMD
      && cmd_i != CMD_CLEAR_STATUS |=> sef_q[`SEF_CMD_ERR_BIT];
   endproperty
   a_cmd_error: assert property (p_cmd_error) // see (R9)
      else $error("Command error class did not set its bit.");

   sequence s_armed_idle;
      opc_q == OPC_ARMED && !busy_i;
   endsequence
   property p_opc_sets;
      @(posedge mclk_i) disable iff (!arst_n_i)
      s_armed_idle ##0 (cmd_i != CMD_CLEAR_STATUS)
      |=> sef_q[`SEF_OPC_BIT];
   endproperty
   a_opc_sets: assert property (p_opc_sets) // see (R14)
      else $error("Completion bit not set after work finished.");

   property p_opc_waits;
      @(posedge mclk_i) disable iff (!arst_n_i)
      opc_q == OPC_ARMED && busy_i && !sef_q[`SEF_OPC_BIT]
      && cmd_i == CMD_NONE |=> !sef_q[`SEF_OPC_BIT];
   endproperty
   a_opc_waits: assert property (p_opc_waits) // see (R14)
      else $error("Completion bit set while still busy.");

   property p_sticky;
      @(posedge mclk_i) disable iff (!arst_n_i)
      cmd_i == CMD_NONE |=> (sef_q & $past(sef_q)) == $past(sef_q);
   endproperty
   a_sticky: assert property (p_sticky) // see (R19)
      else $error("Event bit dropped without read or clear.");

   property p_exec_error;
      @(posedge mclk_i) disable iff (!arst_n_i)
      err_valid_i && err_class_i == `ERR_CLASS_EXEC
      && cmd_i != CMD_CLEAR_STATUS |=> sef_q[`SEF_EXEC_ERR_BIT];
   endproperty
   a_exec_error: assert property (p_exec_error) // see (R10)
      else $error("Execution error class did not set its bit.");

   property p_device_error;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (vi_error_i && vi_ques_i
       || err_valid_i && err_class_i == `ERR_CLASS_DEV)
      && cmd_i != CMD_CLEAR_STATUS |=> sef_q[`SEF_DEVICE_ERR_BIT];
   endproperty
   a_device_error: assert property (p_device_error) // see (R11)
      else $error("Device error cause did not set its bit.");

   property p_query_error;
      @(posedge mclk_i) disable iff (!arst_n_i)
      err_valid_i && err_class_i == `ERR_CLASS_QUERY
      && cmd_i != CMD_CLEAR_STATUS |=> sef_q[`SEF_QUERY_ERR_BIT];
   endproperty
   a_query_error: assert property (p_query_error) // see (R12)
      else $error("Query error class did not set its bit.");

   property p_service_request;
      @(posedge mclk_i) disable iff (!arst_n_i)
      ##1 stb_q[`STB_RQS_BIT] == |(stb_q & $past(srv_enable_i) & 8'hBF);
   endproperty
   a_service_request: assert property (p_service_request) // see (R17)
      else $error("Service request bit disagrees with enabled status.");

   property p_unused_zero;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (sef_q & ~`SEF_USED_MASK) == 8'h00 && stb_q[1:0] == 2'b00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) // see (R6)
      else $error("An unused event or status bit is set.");
endmodule

// ===== verification/host_controller_model.sv
// Remote host controller that issues commands on the instrument link.
// Assumes the unit takes one command per rising edge of mclk_i.
module host_controller_model
   import event_status_pkg::*;
(
   input  wire logic  mclk_i,
   output cmd_t       cmd_o,
   output logic [7:0] data_o,
   output logic [5:0] index_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_o = CMD_NONE;
      data_o = 8'h00;
      index_o = 6'h00;
   end
   // Released data is inverted so that a stale value is never read as good.
   task automatic issue(input cmd_t c, input logic [7:0] d);
      cmd_o <= c;
      data_o <= d;
      index_o <= d[5:0];
      @(posedge mclk_i);
      cmd_o <= CMD_NONE;
      data_o <= ~d;
   endtask
endmodule

// ===== verification/standard_event_status_unit_tb.sv
// Self-checking bench for the standard event status unit.
// Assumes the host model drives the command link and the bench the rest.
module standard_event_status_unit_tb
   import event_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary filler value.
   typedef struct packed {
      logic       ev;
      logic [3:0] cls;
      logic       vi;
      logic [7:0] mask;
      logic [7:0] flags;
   } row_t;
   row_t rows [6] = '{
      '{1'b1, 4'h1, 1'b0, 8'h3D, 8'h20}, '{1'b1, 4'h2, 1'b0, 8'h3D, 8'h10},
      '{1'b1, 4'h3, 1'b0, 8'h3D, 8'h08}, '{1'b1, 4'h4, 1'b0, 8'h00, 8'h04},
      '{1'b1, 4'h5, 1'b0, 8'hFF, 8'h00}, '{1'b0, 4'h0, 1'b1, 8'h08, 8'h08}};
   logic mclk_i = 0, arst_n_i = 0, err_valid_i = 0, vi_error_i = 0;
   logic vi_ques_i = 0, busy_i = 0, oper_i = 0, ques_i = 0, mav_i = 0;
   logic [3:0] err_class_i = 4'h0;
   logic [7:0] srv_i = 8'h00;
   cmd_t cmd;
   logic [7:0] cdata, resp_data_o, stb_o, mask_o, flags_o;
   logic [5:0] idx;
   logic flush_o, resp_valid_o;
   int n_mismatch = 0, compares = 0, cycles = 0;
   host_controller_model host (.mclk_i(mclk_i), .cmd_o(cmd),
      .data_o(cdata), .index_o(idx));
   standard_event_status_unit #(.MAKER_CHAR(MAKER)) dut (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_i(cmd),
      .cmd_data_i(cdata), .err_valid_i(err_valid_i),
      .err_class_i(err_class_i), .vi_error_i(vi_error_i),
      .vi_ques_i(vi_ques_i), .busy_i(busy_i), .oper_summary_i(oper_i),
      .ques_summary_i(ques_i), .msg_avail_i(mav_i), .srv_enable_i(srv_i),
      .idn_index_i(idx), .err_queue_flush_o(flush_o),
      .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
      .status_summary_byte_o(stb_o), .event_enable_mask_o(mask_o),
      .standard_event_flags_o(flags_o));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic complete_run();
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Leaves the bench 1 ns after the edge that took the command.
   task automatic ask(input cmd_t c, input logic [7:0] d);
      @(posedge mclk_i);
      host.issue(c, d);
      #1;
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      #1;
      check(mask_o, 8'h00);
      check(flags_o | stb_o, 8'h00);
      for (int i = 0; i < 6; i++) begin
         ask(CMD_WRITE_MASK, rows[i].mask);
         ask(CMD_READ_MASK, 8'h00);
         check(resp_data_o, rows[i].mask);
         @(posedge mclk_i);
         err_valid_i <= rows[i].ev;
         err_class_i <= rows[i].cls;
         vi_error_i <= rows[i].vi;
         vi_ques_i <= rows[i].vi;
         @(posedge mclk_i);
         {err_valid_i, vi_error_i, vi_ques_i} <= 3'b000;
         @(posedge mclk_i);
         #1;
         check(8'(stb_o[5]), 8'(|(rows[i].flags & rows[i].mask)));
         ask(CMD_READ_FLAGS, 8'h00);
         check(resp_data_o, rows[i].flags);
         check(8'(resp_valid_o), 8'h01);
         check(flags_o, 8'h00);
      end
      @(posedge mclk_i);
      {oper_i, ques_i, mav_i, srv_i} <= {3'b111, 8'h08};
      repeat (3) @(posedge mclk_i);
      #1;
      check(stb_o, 8'hD8);
      @(posedge mclk_i);
      {oper_i, ques_i, mav_i, srv_i, busy_i} <= {11'h000, 1'b1};
      ask(CMD_OP_COMPLETE, 8'h00);
      ask(CMD_READ_MASK, 8'h00);
      check(8'(resp_valid_o), 8'h01);
      repeat (4) @(posedge mclk_i);
      busy_i <= 1'b0;
      #1;
      check(flags_o, 8'h00);
      repeat (3) @(posedge mclk_i);
      #1;
      check(flags_o, 8'h01);
      ask(CMD_READ_FLAGS, 8'h00);
      check(resp_data_o, 8'h01);
      @(posedge mclk_i);
      {busy_i, err_valid_i, err_class_i} <= {2'b11, 4'h1};
      @(posedge mclk_i);
      err_valid_i <= 1'b0;
      ask(CMD_OP_COMPLETE, 8'h00);
      ask(CMD_CLEAR_STATUS, 8'h00);
      check(8'(flush_o), 8'h01);
      check(flags_o, 8'h00);
      check(mask_o, 8'h08);
      @(posedge mclk_i);
      busy_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      check(flags_o, 8'h00);
      ask(CMD_READ_IDENT, 8'h00);
      check(resp_data_o, MAKER);
      ask(CMD_READ_IDENT, 8'h05);
      check(resp_data_o, 8'h2C);
      ask(CMD_READ_IDENT, 8'h24);
      check(resp_data_o, 8'h2D);
      ask(CMD_READ_IDENT, 8'h28);
      check(resp_data_o, 8'h00);
      // A reset in mid-run must drop the mask back to its default.
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(mask_o, 8'h00);
      @(posedge mclk_i);
      arst_n_i <= 1'b1;
      ask(CMD_READ_MASK, 8'h00);
      check(resp_data_o, 8'h00);
      complete_run();
   end
endmodule
